// >>> spp_pkg.sv
// Constants shared by the serial program/verify port
`default_nettype none
package spp_pkg;
    // Serial framing
    localparam int CMD_BITS   = 6;
    localparam int WORD_BITS  = 14;
    localparam int XFER_BITS  = CMD_BITS + WORD_BITS;
    localparam int FRAME_LAST = 15;
    localparam int LOAD_FIRST = 1;
    localparam int LOAD_LAST  = 14;
    localparam int READ_FIRST = 2;
    // Addresses
    localparam logic [13:0] ADDR_RESET = 14'h0000;
    localparam logic [13:0] ID_BASE    = 14'h2000;
    localparam int          ID_BITS    = 4;
    localparam int          ID_COUNT   = 4;
    localparam int          MEM_WORDS  = 1024;
    localparam int          FIFO_DEPTH = 4;
    // Commands, sent LSB first
    localparam logic [5:0] CMD_LOAD_CONFIG = 6'h00;
    localparam logic [5:0] CMD_LOAD_DATA   = 6'h02;
    localparam logic [5:0] CMD_READ_DATA   = 6'h04;
    localparam logic [5:0] CMD_INC_ADDR    = 6'h06;
    // Cell write time
    localparam int CLK_PERIOD_NS = 5;
    localparam int WRITE_TIME_NS = 100;
    localparam int WRITE_CYCLES  = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    typedef enum logic [1:0] {L_CMD, L_LOAD, L_READ} spp_link_t;
    typedef enum logic {C_IDLE, C_WRITE} spp_core_t;
endpackage : spp_pkg
`default_nettype wire

// >>> spp_port.sv
// Serial program/verify port: link logic, command FIFO and memory access core
`default_nettype none

module spp_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             flush,
    // Fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] store [DEPTH];
    logic [PW-1:0]    wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
    logic [PW:0]      count_r, count_nxt;
    logic             push, pop;

    always_comb begin
        inReady   = (count_r != (PW+1)'(DEPTH));
        outValid  = (count_r != '0);
        outData   = store[rdPtr_r];
        push      = inValid && inReady;
        pop       = outValid && outReady;
        wrPtr_nxt = push ? PW'((wrPtr_r + 1'b1) % DEPTH) : wrPtr_r;
        rdPtr_nxt = pop ? PW'((rdPtr_r + 1'b1) % DEPTH) : rdPtr_r;
        count_nxt = count_r + (PW+1)'(push) - (PW+1)'(pop);
        if (flush) begin
            wrPtr_nxt = '0;
            rdPtr_nxt = '0;
            count_nxt = '0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            wrPtr_r <= wrPtr_nxt;
            rdPtr_r <= rdPtr_nxt;
            count_r <= count_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            store[wrPtr_r] <= inData;
        end
    end
endmodule : spp_fifo

// Operation
// - In the mode one pin is serial clock, the other serial data, both Schmitt.
// - Only clock and data lines are needed besides power, ground, programming supply.
// - Entering the mode after reset sets the address counter to zero.
// - Every transaction starts with a six-bit command shifted in on data.
// - Load commands take a 14-bit word; read commands return a 14-bit word. The code's load configuration command takes none.
// - Four identification words sit just above program memory at a fixed range.
// - Identification words are unreachable when running, readable and writable in mode.
// - Only the low four bits of each identification word are stored.
// - With protection unprogrammed, program memory is readable through the verify path.
module spp_port #(
    parameter int MEM_WORDS = spp_pkg::MEM_WORDS
) (
    // Core clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Device pins, split into in/out/enable; Schmitt buffering sits in the pad
    input  wire logic        progClockPin,
    output logic             progClockPinOut,
    output logic             progClockPinOe_n,
    input  wire logic        progDataPin,
    output logic             progDataPinOut,
    output logic             progDataPinOe_n,
    input  wire logic        highVoltageEntryLevel,
    // Ordinary port logic sharing the two pins
    input  wire logic        gpioClkOut,
    input  wire logic        gpioClkOe_n,
    input  wire logic        gpioDataOut,
    input  wire logic        gpioDataOe_n,
    output logic             gpioClkIn,
    output logic             gpioDataIn,
    // Configuration and status
    input  wire logic        codeProtect_n,
    output logic             progMode,
    output logic             linkOverrun,
    // Instruction fetch
    input  wire logic [12:0] fetchAddr,
    output logic      [13:0] fetchWord
);
    localparam int AW = $clog2(MEM_WORDS);
    localparam int XW = spp_pkg::XFER_BITS;
    localparam int WW = spp_pkg::WORD_BITS;

    function automatic logic isLoad(input logic [5:0] c);
        return c == spp_pkg::CMD_LOAD_DATA;
    endfunction : isLoad

    function automatic logic isIdAddr(input logic [13:0] a);
        return a[13:2] == spp_pkg::ID_BASE[13:2];
    endfunction : isIdAddr

    // ---------------- Entry detection, core clock ----------------
    logic hvS1_r, hvS2_r, hvPrev_r, ckS1_r, ckS2_r, dtS1_r, dtS2_r;
    logic progMode_r, progMode_nxt;

    always_comb begin
        progMode_nxt = progMode_r;
        if (!hvS2_r) begin
            progMode_nxt = 1'b0;
        end else if (!hvPrev_r && !ckS2_r && !dtS2_r) begin
            progMode_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            {hvS1_r, hvS2_r, hvPrev_r} <= 3'h0;
            {ckS1_r, ckS2_r, dtS1_r, dtS2_r} <= 4'h0;
            progMode_r <= 1'b0;
        end else begin
            hvS1_r     <= highVoltageEntryLevel;
            hvS2_r     <= hvS1_r;
            hvPrev_r   <= hvS2_r;
            ckS1_r     <= progClockPin;
            ckS2_r     <= ckS1_r;
            dtS1_r     <= progDataPin;
            dtS2_r     <= dtS1_r;
            progMode_r <= progMode_nxt;
        end
    end

    // Link held in reset outside the mode; clock pin is low at release
    logic linkRst_n;
    assign linkRst_n = reset_n & progMode_r;
    assign progMode  = progMode_r;

    // ---------------- Link logic, programming clock ----------------
    spp_pkg::spp_link_t lState_r, lState_nxt;
    logic [4:0]    bitCnt_r, bitCnt_nxt;
    logic [5:0]    cmdShift_r, cmdShift_nxt, cmd_r, cmd_nxt;
    logic [WW-1:0] inShift_r, inShift_nxt, outShift_r, outShift_nxt;
    logic [XW-1:0] xferWord_r, xferWord_nxt;
    logic          xferTgl_r, xferTgl_nxt, ackS1_r, ackS2_r;
    logic          rdS1_r, rdS2_r, rdSeen_r, rdSeen_nxt;
    logic          dataOut_r, dataOut_nxt, overrun_r, overrun_nxt, drive_r;
    logic [WW-1:0] readWord_r;
    logic          emit;
    logic [XW-1:0] emitWord;
    logic          xS1_r, xS2_r, xferSeen_r, xferSeen_nxt, rdTgl_r, rdTgl_nxt;

    always_comb begin
        lState_nxt   = lState_r;
        bitCnt_nxt   = bitCnt_r + 5'd1;
        cmdShift_nxt = cmdShift_r;
        cmd_nxt      = cmd_r;
        inShift_nxt  = inShift_r;
        outShift_nxt = outShift_r;
        rdSeen_nxt   = rdSeen_r;
        dataOut_nxt  = 1'b0;
        emit         = 1'b0;
        emitWord     = '0;
        case (lState_r)
            spp_pkg::L_CMD: begin
                cmdShift_nxt = {progDataPin, cmdShift_r[5:1]};
                if (bitCnt_r == 5'(spp_pkg::CMD_BITS - 1)) begin
                    bitCnt_nxt = '0;
                    cmd_nxt    = cmdShift_nxt;
                    if (isLoad(cmdShift_nxt)) begin
                        lState_nxt = spp_pkg::L_LOAD;
                    end else begin
                        emit     = 1'b1;
                        emitWord = {cmdShift_nxt, WW'(0)};
                        if (cmdShift_nxt == spp_pkg::CMD_READ_DATA) begin
                            lState_nxt = spp_pkg::L_READ;
                        end
                    end
                end
            end
            spp_pkg::L_LOAD: begin
                if (bitCnt_r >= 5'(spp_pkg::LOAD_FIRST) && bitCnt_r <= 5'(spp_pkg::LOAD_LAST)) begin
                    inShift_nxt = {progDataPin, inShift_r[WW-1:1]};
                end
                if (bitCnt_r == 5'(spp_pkg::FRAME_LAST)) begin
                    emit       = 1'b1;
                    emitWord   = {cmd_r, inShift_r};
                    bitCnt_nxt = '0;
                    lState_nxt = spp_pkg::L_CMD;
                end
            end
            spp_pkg::L_READ: begin
                if (bitCnt_r == 5'(spp_pkg::READ_FIRST)) begin
                    // Word is held still by the core once its toggle is seen
                    if (rdS2_r != rdSeen_r) begin
                        dataOut_nxt  = readWord_r[0];
                        outShift_nxt = {1'b0, readWord_r[WW-1:1]};
                        rdSeen_nxt   = rdS2_r;
                    end else begin
                        outShift_nxt = '0;
                    end
                end else if (bitCnt_r > 5'(spp_pkg::READ_FIRST)) begin
                    dataOut_nxt  = outShift_r[0];
                    outShift_nxt = {1'b0, outShift_r[WW-1:1]};
                end
                if (bitCnt_r == 5'(spp_pkg::FRAME_LAST)) begin
                    bitCnt_nxt = '0;
                    lState_nxt = spp_pkg::L_CMD;
                end
            end
            default: begin
                bitCnt_nxt = '0;
                lState_nxt = spp_pkg::L_CMD;
            end
        endcase
        // Programmer cannot be stalled: an event meeting an unacked one is lost
        xferTgl_nxt  = xferTgl_r;
        xferWord_nxt = xferWord_r;
        overrun_nxt  = overrun_r;
        if (emit && (xferTgl_r == ackS2_r)) begin
            xferTgl_nxt  = ~xferTgl_r;
            xferWord_nxt = emitWord;
        end else if (emit) begin
            overrun_nxt = 1'b1;
        end
    end

    always_ff @(posedge progClockPin or negedge linkRst_n) begin
        if (!linkRst_n) begin
            lState_r   <= spp_pkg::L_CMD;
            bitCnt_r   <= '0;
            cmdShift_r <= '0;
            cmd_r      <= '0;
            inShift_r  <= '0;
            outShift_r <= '0;
            xferWord_r <= '0;
            {xferTgl_r, ackS1_r, ackS2_r} <= 3'h0;
            {rdS1_r, rdS2_r, rdSeen_r}    <= 3'h0;
            dataOut_r  <= 1'b0;
            overrun_r  <= 1'b0;
        end else begin
            lState_r   <= lState_nxt;
            bitCnt_r   <= bitCnt_nxt;
            cmdShift_r <= cmdShift_nxt;
            cmd_r      <= cmd_nxt;
            inShift_r  <= inShift_nxt;
            outShift_r <= outShift_nxt;
            xferWord_r <= xferWord_nxt;
            xferTgl_r  <= xferTgl_nxt;
            ackS1_r    <= xferSeen_r;
            ackS2_r    <= ackS1_r;
            rdS1_r     <= rdTgl_r;
            rdS2_r     <= rdS1_r;
            rdSeen_r   <= rdSeen_nxt;
            dataOut_r  <= dataOut_nxt;
            overrun_r  <= overrun_nxt;
        end
    end

    // Drive edges on the falling clock, clear of programmer sampling
    always_ff @(negedge progClockPin or negedge linkRst_n) begin
        if (!linkRst_n) begin
            drive_r <= 1'b0;
        end else begin
            drive_r <= (lState_r == spp_pkg::L_READ);
        end
    end

    assign linkOverrun = overrun_r;

    // Pin sharing with the ordinary port
    always_comb begin
        progClockPinOut  = gpioClkOut;
        progClockPinOe_n = progMode_r ? 1'b1 : gpioClkOe_n;
        progDataPinOut   = progMode_r ? dataOut_r : gpioDataOut;
        progDataPinOe_n  = progMode_r ? ~drive_r : gpioDataOe_n;
        gpioClkIn        = progMode_r ? 1'b0 : ckS2_r;
        gpioDataIn       = progMode_r ? 1'b0 : dtS2_r;
    end

    // ---------------- Core, core clock ----------------
    logic [WW-1:0]      progMem [MEM_WORDS];
    logic [3:0]         idMem   [spp_pkg::ID_COUNT];
    spp_pkg::spp_core_t cState_r, cState_nxt;
    logic [13:0]        addr_r, addr_nxt;
    logic [4:0]         wait_r, wait_nxt;
    logic [WW-1:0]      readWord_nxt, rdData;
    logic               fifoInReady, fifoValid, fifoPop, memWe, idWe;
    logic [XW-1:0]      fifoWord;
    logic [5:0]         popCmd;
    logic [WW-1:0]      popData;

    spp_fifo #(
        .WIDTH (XW),
        .DEPTH (spp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .reset_n  (reset_n),
        .flush    (!progMode_r),
        .inValid  (progMode_r && (xS2_r != xferSeen_r)),
        .inReady  (fifoInReady),
        .inData   (xferWord_r),
        .outValid (fifoValid),
        .outReady (fifoPop),
        .outData  (fifoWord)
    );

    always_comb begin
        cState_nxt   = cState_r;
        addr_nxt     = addr_r;
        wait_nxt     = wait_r;
        xferSeen_nxt = xferSeen_r;
        rdTgl_nxt    = rdTgl_r;
        readWord_nxt = readWord_r;
        memWe        = 1'b0;
        idWe         = 1'b0;
        popCmd       = fifoWord[XW-1:WW];
        popData      = fifoWord[WW-1:0];
        fifoPop      = progMode_r && (cState_r == spp_pkg::C_IDLE);
        if (isIdAddr(addr_r)) begin
            rdData = {10'h000, idMem[addr_r[1:0]]};
        end else if (addr_r < spp_pkg::ID_BASE) begin
            rdData = codeProtect_n ? progMem[addr_r[AW-1:0]] : '0;
        end else begin
            rdData = '0;
        end
        // Word held in the link's crossing register until the ack returns
        if (progMode_r && (xS2_r != xferSeen_r) && fifoInReady) begin
            xferSeen_nxt = xS2_r;
        end
        case (cState_r)
            spp_pkg::C_IDLE: begin
                if (fifoPop && fifoValid) begin
                    case (popCmd)
                        spp_pkg::CMD_LOAD_CONFIG: addr_nxt = spp_pkg::ID_BASE;
                        spp_pkg::CMD_INC_ADDR:    addr_nxt = addr_r + 14'h0001;
                        spp_pkg::CMD_READ_DATA: begin
                            readWord_nxt = rdData;
                            rdTgl_nxt    = ~rdTgl_r;
                        end
                        spp_pkg::CMD_LOAD_DATA: begin
                            memWe      = (addr_r < spp_pkg::ID_BASE);
                            idWe       = isIdAddr(addr_r);
                            wait_nxt   = 5'(spp_pkg::WRITE_CYCLES - 1);
                            cState_nxt = spp_pkg::C_WRITE;
                        end
                        default: addr_nxt = addr_r;
                    endcase
                end
            end
            spp_pkg::C_WRITE: begin
                wait_nxt = wait_r - 5'd1;
                if (wait_r == '0) begin
                    cState_nxt = spp_pkg::C_IDLE;
                end
            end
            default: cState_nxt = spp_pkg::C_IDLE;
        endcase
        // Leaving the mode returns the core to its entry state
        if (!progMode_r) begin
            cState_nxt   = spp_pkg::C_IDLE;
            addr_nxt     = spp_pkg::ADDR_RESET;
            xferSeen_nxt = 1'b0;
            rdTgl_nxt    = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cState_r   <= spp_pkg::C_IDLE;
            addr_r     <= spp_pkg::ADDR_RESET;
            wait_r     <= '0;
            {xS1_r, xS2_r, xferSeen_r, rdTgl_r} <= 4'h0;
            readWord_r <= '0;
            fetchWord  <= '0;
        end else begin
            cState_r   <= cState_nxt;
            addr_r     <= addr_nxt;
            wait_r     <= wait_nxt;
            xS1_r      <= xferTgl_r;
            xS2_r      <= xS1_r;
            xferSeen_r <= xferSeen_nxt;
            rdTgl_r    <= rdTgl_nxt;
            readWord_r <= readWord_nxt;
            fetchWord  <= progMem[fetchAddr[AW-1:0]];
        end
    end

    always_ff @(posedge clk) begin
        if (memWe) begin
            progMem[addr_r[AW-1:0]] <= popData;
        end
        if (idWe) begin
            idMem[addr_r[1:0]] <= popData[spp_pkg::ID_BITS-1:0];
        end
    end
endmodule : spp_port
`default_nettype wire

// >>> spp_port_props.sv
// Concurrent checks on the serial program/verify port pins and mode
`default_nettype none
module spp_port_props #(
    parameter int MEM_WORDS = 1024
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Device pins
    input wire logic progClockPin,
    input wire logic progClockPinOut,
    input wire logic progClockPinOe_n,
    input wire logic progDataPin,
    input wire logic progDataPinOut,
    input wire logic progDataPinOe_n,
    input wire logic highVoltageEntryLevel,
    // Ordinary port logic
    input wire logic gpioClkOut,
    input wire logic gpioClkOe_n,
    input wire logic gpioDataOut,
    input wire logic gpioDataOe_n,
    input wire logic gpioClkIn,
    input wire logic gpioDataIn,
    // Status
    input wire logic progMode,
    input wire logic linkOverrun
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    mode_clk_oe_a: assert property (progMode |-> progClockPinOe_n)
        else $error("clock pin driven while in programming mode");
    gpio_pass_a: assert property (!progMode |-> progClockPinOe_n == gpioClkOe_n && progClockPinOut == gpioClkOut
        && progDataPinOut == gpioDataOut && progDataPinOe_n == gpioDataOe_n) else $error("pins not following port");
    gpio_block_a: assert property (progMode |-> !gpioClkIn && !gpioDataIn)
        else $error("port inputs not blocked in programming mode");
    entry_cause_a: assert property ($rose(progMode) |-> $past(highVoltageEntryLevel, 3)
        && !$past(progClockPin, 3) && !$past(progDataPin, 3)) else $error("mode entered without proper entry");
    entry_quiet_a: assert property ($rose(progMode) |-> progDataPinOe_n [*4])
        else $error("data pin driven right after entry");
    mode_exit_a: assert property (!highVoltageEntryLevel [*6] |-> !progMode)
        else $error("mode held without entry level");
    mode_hold_a: assert property ((progMode && highVoltageEntryLevel) [*4] |=> progMode)
        else $error("mode dropped while entry level held");
    overrun_clear_a: assert property (!progMode |-> !linkOverrun)
        else $error("overrun flag set outside programming mode");
endmodule : spp_port_props

bind spp_port spp_port_props #(.MEM_WORDS(MEM_WORDS)) u_props (
    .clk(clk), .reset_n(reset_n), .progClockPin(progClockPin), .progClockPinOut(progClockPinOut),
    .progClockPinOe_n(progClockPinOe_n), .progDataPin(progDataPin), .progDataPinOut(progDataPinOut),
    .progDataPinOe_n(progDataPinOe_n), .highVoltageEntryLevel(highVoltageEntryLevel),
    .gpioClkOut(gpioClkOut), .gpioClkOe_n(gpioClkOe_n), .gpioDataOut(gpioDataOut),
    .gpioDataOe_n(gpioDataOe_n), .gpioClkIn(gpioClkIn), .gpioDataIn(gpioDataIn),
    .progMode(progMode), .linkOverrun(linkOverrun));
`default_nettype wire

// >>> spp_prog_model.sv
// Behavioural external programmer driving the serial clock and data pins
`default_nettype none
module spp_prog_model (
    // Pins towards the device
    output var logic        progClk,
    output var logic        hvLevel,
    output var logic        dataDrv,
    output var logic        dataVal,
    input  wire logic       dataLine,
    // Readback
    output var logic [13:0] rdWord,
    output var logic        rdDone
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        progClk = 1'b0;
        hvLevel = 1'b0;
        dataDrv = 1'b1;
        dataVal = 1'b0;
        rdWord  = 14'h0000;
        rdDone  = 1'b0;
    end
    // Data changes only while the clock is low; clock stands low between frames
    task automatic pulse(input logic b);
        dataVal = b;
        #16 progClk = 1'b1;
        #16 progClk = 1'b0;
    endtask : pulse
    task automatic send_cmd(input logic [5:0] c);
        dataDrv = 1'b1;
        for (int i = 0; i < 6; i++) pulse(c[i]);
    endtask : send_cmd
    // Gaps leave room for queued cell writes ahead of this event
    task automatic load_word(input logic [13:0] w);
        send_cmd(spp_pkg::CMD_LOAD_DATA);
        #1100;
        pulse(1'b0);
        for (int i = 0; i < 14; i++) pulse(w[i]);
        pulse(1'b0);
        #1100;
    endtask : load_word
    task automatic read_word();
        send_cmd(spp_pkg::CMD_READ_DATA);
        dataDrv = 1'b0;
        #1100;
        for (int i = 0; i < 16; i++) begin
            #16 progClk = 1'b1;
            #8;
            if (i > 1) rdWord[i-2] = dataLine;
            #8 progClk = 1'b0;
        end
        #16 dataDrv = 1'b1;
        rdDone = 1'b1;
        #1 rdDone = 1'b0;
        #1100;
    endtask : read_word
    task automatic enter(input logic clkLevel);
        dataDrv = 1'b1;
        dataVal = 1'b0;
        progClk = clkLevel;
        #100 hvLevel = 1'b1;
        #200 progClk = 1'b0;
    endtask : enter
    task automatic leave();
        #100 hvLevel = 1'b0;
        #200;
    endtask : leave
endmodule : spp_prog_model
`default_nettype wire

// >>> test_serial_program_verify_port.sv
// Self-checking bench for the serial program/verify port
`default_nettype none
module test_serial_program_verify_port;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk, reset_n, hvLevel, codeProtect_n, progMode, linkOverrun;
    logic        progClockPin, progClockPinOut, progClockPinOe_n;
    logic        progDataPin, progDataPinOut, progDataPinOe_n;
    logic        gpioClkOut, gpioClkOe_n, gpioDataOut, gpioDataOe_n, gpioClkIn, gpioDataIn;
    logic        pClk, dataDrv, dataVal, rdDone;
    logic        floatLvl = 1'b0;
    logic [12:0] fetchAddr;
    logic [13:0] fetchWord, rdWord, w, w0, w1;
    logic [13:0] expQ[$];
    int          err_count = 0;
    int          compares  = 0;

    // Released data line toggles so a stale level never passes
    assign progClockPin = !progClockPinOe_n ? progClockPinOut : pClk;
    assign progDataPin  = !progDataPinOe_n ? progDataPinOut : (dataDrv ? dataVal : floatLvl);
    always @(posedge clk) floatLvl <= !floatLvl;

    spp_port #(.MEM_WORDS(1024)) u_dut (
        .clk(clk), .reset_n(reset_n), .progClockPin(progClockPin), .progClockPinOut(progClockPinOut),
        .progClockPinOe_n(progClockPinOe_n), .progDataPin(progDataPin), .progDataPinOut(progDataPinOut),
        .progDataPinOe_n(progDataPinOe_n), .highVoltageEntryLevel(hvLevel), .gpioClkOut(gpioClkOut),
        .gpioClkOe_n(gpioClkOe_n), .gpioDataOut(gpioDataOut), .gpioDataOe_n(gpioDataOe_n),
        .gpioClkIn(gpioClkIn), .gpioDataIn(gpioDataIn), .codeProtect_n(codeProtect_n),
        .progMode(progMode), .linkOverrun(linkOverrun), .fetchAddr(fetchAddr), .fetchWord(fetchWord));
    spp_prog_model u_prog (.progClk(pClk), .hvLevel(hvLevel), .dataDrv(dataDrv), .dataVal(dataVal),
        .dataLine(progDataPin), .rdWord(rdWord), .rdDone(rdDone));

    task automatic check_word(input string what, input logic [13:0] exp, input logic [13:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check_word
    task automatic check_bit(input string what, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask : check_bit
    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run
    task automatic wait_mode(input logic v);
        int n;
        n = 0;
        while (progMode !== v && n < 60) begin
            @(negedge clk);
            n++;
        end
        check_bit("progMode", v, progMode);
        if (progMode !== v) begin
            complete_run();
        end
    endtask : wait_mode
    task automatic read_expect(input logic [13:0] e);
        expQ.push_back(e);
        u_prog.read_word();
    endtask : read_expect
    task automatic fetch_check(input logic [12:0] a, input logic [13:0] e);
        @(negedge clk);
        fetchAddr = a;
        @(negedge clk);
        check_word("fetch", e, fetchWord);
    endtask : fetch_check
    task automatic gap_cmd(input logic [5:0] c);
        u_prog.send_cmd(c);
        #1100;
    endtask : gap_cmd

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Readback monitor pairs each returned word with the oldest note
    initial begin
        forever begin
            @(posedge rdDone);
            if (expQ.size() > 0) begin
                check_word("readback", expQ.pop_front(), rdWord);
            end else begin
                check_bit("read expected", 1'b1, 1'b0);
            end
        end
    end
    initial begin
        #300000;
        check_bit("watchdog", 1'b1, 1'b0);
        complete_run();
    end
    initial begin
        reset_n = 1'b0;
        codeProtect_n = 1'b1;
        fetchAddr = 13'h0000;
        {gpioClkOut, gpioClkOe_n, gpioDataOut, gpioDataOe_n} = 4'h5;
        void'($urandom(14));
        repeat (10) @(negedge clk);
        reset_n = 1'b1;
        for (int i = 0; i < 4; i++) begin
            @(negedge clk);
            {gpioClkOut, gpioClkOe_n, gpioDataOut, gpioDataOe_n} = 4'($urandom);
            @(negedge clk);
            check_bit("clock oe", gpioClkOe_n, progClockPinOe_n);
            check_bit("data out", gpioDataOut, progDataPinOut);
            check_bit("clock out", gpioClkOut, progClockPinOut);
            check_bit("data oe", gpioDataOe_n, progDataPinOe_n);
            @(negedge clk);
            check_bit("clock in", gpioClkOe_n ? 1'b0 : gpioClkOut, gpioClkIn);
            check_bit("data in", gpioDataOe_n ? 1'b0 : gpioDataOut, gpioDataIn);
        end
        gpioClkOe_n = 1'b1;
        gpioDataOe_n = 1'b1;
        $display("test port pass-through done");
        u_prog.enter(1'b1);
        repeat (20) @(negedge clk);
        check_bit("refused entry", 1'b0, progMode);
        u_prog.leave();
        u_prog.enter(1'b0);
        wait_mode(1'b1);
        $display("test entry done");
        w0 = 14'($urandom);
        w1 = 14'($urandom);
        u_prog.load_word(w0);
        read_expect(w0);
        @(negedge clk) codeProtect_n = 1'b0;
        read_expect(14'h0000);
        @(negedge clk) codeProtect_n = 1'b1;
        read_expect(w0);
        gap_cmd(spp_pkg::CMD_INC_ADDR);
        u_prog.load_word(w1);
        gap_cmd(6'h3F);
        read_expect(w1);
        $display("test program memory done");
        gap_cmd(spp_pkg::CMD_LOAD_CONFIG);
        for (int i = 0; i < 5; i++) begin
            w = 14'($urandom);
            u_prog.load_word(w);
            read_expect(i < 4 ? {10'h000, w[3:0]} : 14'h0000);
            gap_cmd(spp_pkg::CMD_INC_ADDR);
        end
        check_bit("overrun", 1'b0, linkOverrun);
        $display("test id locations done");
        u_prog.leave();
        wait_mode(1'b0);
        fetch_check(13'h0000, w0);
        fetch_check(13'h0001, w1);
        fetch_check(13'h1000, w0);
        check_bit("queue empty", 1'b1, expQ.size() == 0);
        $display("test exit and fetch done");
        complete_run();
    end
endmodule : test_serial_program_verify_port
`default_nettype wire
